// *** rtl/miw_edge_detect.sv ***
// One-bit change and edge detector on a synchronous input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
module miw_edge_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic level,
    output logic changed,
    output logic rose,
    output logic fell
);
    typedef struct packed {
        logic last;
        logic seen;
    } miw_edge_s;

    miw_edge_s state;
    miw_edge_s next_state;

    always_comb begin
        next_state = state;
        next_state.last = level;
        next_state.seen = 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // First cycle after reset only primes the history
    assign changed = state.seen && (level != state.last);
    assign rose = state.seen && level && !state.last;
    assign fell = state.seen && !level && state.last;
endmodule : miw_edge_detect

// *** rtl/miw_irq_ctrl.sv ***
// Interrupt controller top with watchdog.
// Assumes events are one-cycle pulses and pins are synchronous to clk.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module miw_irq_ctrl #(
    parameter int WDT_CYC_0 = miw_pkg::WDT_CYC_0,
    parameter int WDT_CYC_1 = miw_pkg::WDT_CYC_1,
    parameter int WDT_CYC_2 = miw_pkg::WDT_CYC_2,
    parameter int WDT_CYC_3 = miw_pkg::WDT_CYC_3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    input wire logic enableIrqInstr,
    input wire logic disableIrqInstr,
    input wire logic returnFromIsrInstr,
    input wire logic softTrapInstr,
    input wire logic clearWatchdogInstr,
    input wire logic timerAOverflow,
    input wire logic timerBUnderflow,
    input wire logic timerCUnderflow,
    input wire logic timerDUnderflow,
    input wire logic lowVoltageEvent,
    input wire logic conversionDone,
    input wire logic comparatorOut,
    input wire logic [7:0] portAIn,
    input wire logic [5:0] portBIn,
    input wire logic [7:0] portAIsInput,
    input wire logic [5:0] portBIsInput,
    input wire logic watchdogCfgEnable,
    input wire logic watchdogIrqMode,
    input wire logic [1:0] watchdogPeriodSel,
    output logic fetchRedirect,
    output logic [10:0] fetchVector,
    output logic globalIrqEnable,
    output logic inService,
    output logic watchdogChipReset
);
    typedef struct packed {
        logic [miw_pkg::NUM_SRC-1:0] flags;
        logic [miw_pkg::NUM_SRC-1:0] enables;
        logic globalIrqEnable;
        logic inService;
        logic timeoutStatusN;
        logic [7:0] powerControl;
        logic [7:0] prescaleCtrl;
        logic [7:0] portAWakeEnable;
        logic [5:0] portBWakeEnable;
        logic [2:0] extCfg;
        logic cmpRegistered;
        logic [7:0] readData;
        logic fetchRedirect;
        logic [10:0] fetchVector;
        logic watchdogChipReset;
    } miw_ctrl_s;

    miw_ctrl_s state;
    miw_ctrl_s next_state;

    logic [13:0] pinLevels;
    logic [13:0] pinChanged;
    logic [13:0] pinRose;
    logic [13:0] pinFell;
    logic cmpChanged;
    logic watchdogExpired;
    logic [miw_pkg::NUM_SRC-1:0] events;
    logic [miw_pkg::NUM_SRC-1:0] clearMask;
    logic [13:0] wakeMask;
    logic pinChangeEvent;
    logic extAEvent;
    logic extBEvent;
    logic pending;
    logic watchdogRun;

    assign pinLevels = {portBIn, portAIn};

    // Logic that repeats per pin: one detector each
    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : gPin
            miw_edge_detect uDet (
                .clk(clk),
                .reset(reset),
                .level(pinLevels[g]),
                .changed(pinChanged[g]),
                .rose(pinRose[g]),
                .fell(pinFell[g])
            );
        end
    endgenerate

    miw_edge_detect uCmp (
        .clk(clk),
        .reset(reset),
        .level(comparatorOut),
        .changed(cmpChanged),
        .rose(),
        .fell()
    );

    assign watchdogRun = watchdogCfgEnable
        && state.powerControl[miw_pkg::POWER_WDT_RUN_BIT];

    // counter runs on clk; gated by the config enable and the power control run bit
    miw_watchdog #(
        .CYC_0(WDT_CYC_0),
        .CYC_1(WDT_CYC_1),
        .CYC_2(WDT_CYC_2),
        .CYC_3(WDT_CYC_3)
    ) uWdt (
        .clk(clk),
        .reset(reset),
        .run(watchdogRun),
        .clear(clearWatchdogInstr),
        .periodSel(watchdogPeriodSel),
        .prescaleOn(state.prescaleCtrl[miw_pkg::PRESCALE_ASSIGN_BIT]),
        .rateSel(state.prescaleCtrl[2:0]),
        .irqMode(watchdogIrqMode),
        .expired(watchdogExpired)
    );

    always_comb begin
        wakeMask = {portBIsInput & state.portBWakeEnable,
                    portAIsInput & state.portAWakeEnable};
        // external select masks pin change on the two shared pins
        if (state.extCfg[miw_pkg::EXT_A_SEL_BIT]) begin
            wakeMask[8] = 1'b0;
        end
        if (state.extCfg[miw_pkg::EXT_B_SEL_BIT]) begin
            wakeMask[9] = 1'b0;
        end
        pinChangeEvent = |(pinChanged & wakeMask);
        // polarity bit high selects rising edge
        if (state.extCfg[miw_pkg::EXT_EDGE_BIT]) begin
            extAEvent = state.extCfg[miw_pkg::EXT_A_SEL_BIT] && pinRose[8];
            extBEvent = state.extCfg[miw_pkg::EXT_B_SEL_BIT] && pinRose[9];
        end else begin
            extAEvent = state.extCfg[miw_pkg::EXT_A_SEL_BIT] && pinFell[8];
            extBEvent = state.extCfg[miw_pkg::EXT_B_SEL_BIT] && pinFell[9];
        end

        events = '0;
        events[miw_pkg::SRC_TIMER_A] = timerAOverflow;
        events[miw_pkg::SRC_TIMER_B] = timerBUnderflow;
        events[miw_pkg::SRC_TIMER_C] = timerCUnderflow;
        events[miw_pkg::SRC_TIMER_D] = timerDUnderflow;
        events[miw_pkg::SRC_EXT_A] = extAEvent;
        events[miw_pkg::SRC_EXT_B] = extBEvent;
        events[miw_pkg::SRC_WATCHDOG] = watchdogExpired && watchdogIrqMode;
        events[miw_pkg::SRC_PIN_CHANGE] = pinChangeEvent;
        events[miw_pkg::SRC_LVD] = lowVoltageEvent;
        // only after the oscillator read resynced the registered output
        events[miw_pkg::SRC_CMP] = cmpChanged && (state.cmpRegistered != comparatorOut)
            && (state.cmpRegistered == !comparatorOut);
        events[miw_pkg::SRC_ADC] = conversionDone;

        clearMask = '0;
        next_state = state;
        next_state.fetchRedirect = 1'b0;
        next_state.watchdogChipReset = 1'b0;
        next_state.readData = 8'h00;

        if (writeStrobe) begin
            if (addr == miw_pkg::ADDR_FLAG) begin
                clearMask[7:0] = ~writeData;
            end else if (addr == miw_pkg::ADDR_ENABLE) begin
                next_state.enables[7:0] = writeData;
            end else if (addr == miw_pkg::ADDR_POWER) begin
                next_state.powerControl = writeData;
            end else if (addr == miw_pkg::ADDR_PRESCALE) begin
                next_state.prescaleCtrl = writeData;
            end else if (addr == miw_pkg::ADDR_WAKE_A) begin
                next_state.portAWakeEnable = writeData;
            end else if (addr == miw_pkg::ADDR_WAKE_B) begin
                next_state.portBWakeEnable = writeData[5:0];
            end else if (addr == miw_pkg::ADDR_EXT_CFG) begin
                next_state.extCfg = writeData[2:0];
            end else if (addr == miw_pkg::ADDR_OSC_CTRL) begin
                clearMask[miw_pkg::NUM_SRC-1:8] = ~writeData[2:0];
                next_state.enables[miw_pkg::NUM_SRC-1:8] = writeData[6:4];
            end
        end

        // sticky; a new event wins over the clearing write
        next_state.flags = (state.flags & ~clearMask) | events;

        if (readStrobe) begin
            if (addr == miw_pkg::ADDR_FLAG) begin
                // flag visible only while its enable is set
                next_state.readData = state.flags[7:0] & state.enables[7:0];
            end else if (addr == miw_pkg::ADDR_ENABLE) begin
                next_state.readData = state.enables[7:0];
            end else if (addr == miw_pkg::ADDR_STATUS) begin
                next_state.readData[miw_pkg::STATUS_TIMEOUT_BIT] = state.timeoutStatusN;
            end else if (addr == miw_pkg::ADDR_POWER) begin
                next_state.readData = state.powerControl;
            end else if (addr == miw_pkg::ADDR_PRESCALE) begin
                next_state.readData = state.prescaleCtrl;
            end else if (addr == miw_pkg::ADDR_WAKE_A) begin
                next_state.readData = state.portAWakeEnable;
            end else if (addr == miw_pkg::ADDR_WAKE_B) begin
                next_state.readData = {2'h0, state.portBWakeEnable};
            end else if (addr == miw_pkg::ADDR_EXT_CFG) begin
                next_state.readData = {5'h00, state.extCfg};
            end else if (addr == miw_pkg::ADDR_OSC_CTRL) begin
                next_state.readData = {comparatorOut, state.enables[10:8], 1'b0,
                    state.flags[10:8] & state.enables[10:8]};
                next_state.cmpRegistered = comparatorOut;
            end
        end

        // each timeout clears status and takes the configured action
        if (watchdogExpired) begin
            next_state.timeoutStatusN = 1'b0;
            next_state.watchdogChipReset = !watchdogIrqMode;
        end else if (clearWatchdogInstr
                && state.prescaleCtrl[miw_pkg::PRESCALE_ASSIGN_BIT]) begin
            next_state.timeoutStatusN = 1'b1;
        end

        pending = |(state.flags & state.enables);

        if (enableIrqInstr) begin
            next_state.globalIrqEnable = 1'b1;
        end else if (disableIrqInstr) begin
            next_state.globalIrqEnable = 1'b0;
        end

        if (softTrapInstr) begin
            next_state.fetchRedirect = 1'b1;
            next_state.fetchVector = miw_pkg::VEC_SOFT_TRAP;
            next_state.globalIrqEnable = 1'b0;
            next_state.inService = 1'b1;
        end else if (returnFromIsrInstr) begin
            next_state.globalIrqEnable = 1'b1;
            next_state.inService = 1'b0;
        end else if (pending && state.globalIrqEnable && !state.fetchRedirect) begin
            next_state.fetchRedirect = 1'b1;
            next_state.fetchVector = miw_pkg::VEC_HW_IRQ;
            next_state.globalIrqEnable = 1'b0;
            next_state.inService = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
            state.timeoutStatusN <= 1'b1;
            state.powerControl <= miw_pkg::POWER_RESET;
            state.prescaleCtrl <= miw_pkg::PRESCALE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign readData = state.readData;
    assign fetchRedirect = state.fetchRedirect;
    assign fetchVector = state.fetchVector;
    assign globalIrqEnable = state.globalIrqEnable;
    assign inService = state.inService;
    assign watchdogChipReset = state.watchdogChipReset;
endmodule : miw_irq_ctrl

// *** rtl/miw_pkg.sv ***
// Constants shared by the interrupt controller and watchdog.
// Assumes a 20 MHz instruction clock.
package miw_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int NUM_SRC = 11;

    // Interrupt source bit positions in the flag and enable registers
    localparam int SRC_TIMER_A = 0;
    localparam int SRC_TIMER_B = 1;
    localparam int SRC_TIMER_C = 2;
    localparam int SRC_TIMER_D = 3;
    localparam int SRC_EXT_A = 4;
    localparam int SRC_EXT_B = 5;
    localparam int SRC_WATCHDOG = 6;
    localparam int SRC_PIN_CHANGE = 7;
    localparam int SRC_LVD = 8;
    localparam int SRC_CMP = 9;
    localparam int SRC_ADC = 10;

    // Register addresses
    localparam logic [3:0] ADDR_FLAG = 4'h0;
    localparam logic [3:0] ADDR_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_POWER = 4'h3;
    localparam logic [3:0] ADDR_PRESCALE = 4'h4;
    localparam logic [3:0] ADDR_WAKE_A = 4'h5;
    localparam logic [3:0] ADDR_WAKE_B = 4'h6;
    localparam logic [3:0] ADDR_EXT_CFG = 4'h7;
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h8;

    // Field positions
    localparam int STATUS_TIMEOUT_BIT = 4;
    localparam int POWER_WDT_RUN_BIT = 7;
    localparam int PRESCALE_ASSIGN_BIT = 3;
    localparam int EXT_A_SEL_BIT = 0;
    localparam int EXT_B_SEL_BIT = 1;
    localparam int EXT_EDGE_BIT = 2;
    localparam int OSC_CMP_OUT_BIT = 7;

    // Fetch vectors
    localparam logic [10:0] VEC_SOFT_TRAP = 11'h001;
    localparam logic [10:0] VEC_HW_IRQ = 11'h008;

    // Reset values
    localparam logic [7:0] POWER_RESET = 8'h80;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    // Watchdog base periods in microseconds (3.5 ms written as 3500 us)
    localparam int WDT_PERIOD_0_US = 3500;
    localparam int WDT_PERIOD_1_US = 15000;
    localparam int WDT_PERIOD_2_US = 60000;
    localparam int WDT_PERIOD_3_US = 250000;
    localparam int WDT_CYC_0 = WDT_PERIOD_0_US * (CLK_HZ / 1000000);
    localparam int WDT_CYC_1 = WDT_PERIOD_1_US * (CLK_HZ / 1000000);
    localparam int WDT_CYC_2 = WDT_PERIOD_2_US * (CLK_HZ / 1000000);
    localparam int WDT_CYC_3 = WDT_PERIOD_3_US * (CLK_HZ / 1000000);
    localparam int WDT_CNT_W = 23;
endpackage : miw_pkg

// *** rtl/miw_watchdog.sv ***
// Watchdog counter with its base period select and shared prescaler.
// Counts cycles of clk; there is no separate watchdog oscillator tick input.
`timescale 1ns/1ps
module miw_watchdog #(
    parameter int CYC_0 = miw_pkg::WDT_CYC_0,
    parameter int CYC_1 = miw_pkg::WDT_CYC_1,
    parameter int CYC_2 = miw_pkg::WDT_CYC_2,
    parameter int CYC_3 = miw_pkg::WDT_CYC_3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] periodSel,
    input wire logic prescaleOn,
    input wire logic [2:0] rateSel,
    input wire logic irqMode,
    output logic expired
);
    typedef struct packed {
        logic [miw_pkg::WDT_CNT_W-1:0] count;
        logic [8:0] prescale;
        logic expired;
    } miw_wdt_s;

    miw_wdt_s state;
    miw_wdt_s next_state;
    logic [miw_pkg::WDT_CNT_W-1:0] limit;
    logic [8:0] ratio;
    logic baseDone;

    always_comb begin
        case (periodSel)
            2'h0: limit = miw_pkg::WDT_CNT_W'(CYC_0 - 1);
            2'h1: limit = miw_pkg::WDT_CNT_W'(CYC_1 - 1);
            2'h2: limit = miw_pkg::WDT_CNT_W'(CYC_2 - 1);
            default: limit = miw_pkg::WDT_CNT_W'(CYC_3 - 1);
        endcase
        ratio = 9'h001 << (9'(rateSel) + 9'(irqMode));
        if (!prescaleOn) begin
            ratio = 9'h001;
        end
        baseDone = (state.count == limit);
        next_state = state;
        next_state.expired = 1'b0;
        if (clear) begin
            next_state.count = '0;
            next_state.prescale = '0;
        end else if (run) begin
            if (baseDone) begin
                next_state.count = '0;
                if (state.prescale + 9'h001 >= ratio) begin
                    next_state.prescale = '0;
                    next_state.expired = 1'b1;
                end else begin
                    next_state.prescale = state.prescale + 9'h001;
                end
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = state.expired;
endmodule : miw_watchdog

// *** verification/miw_core_model.sv ***
// Core sequencing model: issues instruction pulses and logs redirects.
// Assumes redirects are one-cycle registered pulses.
`timescale 1ns/1ps
module miw_core_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic fetchRedirect,
    input wire logic [10:0] fetchVector,
    output logic [4:0] instr
);
    int redirects;
    logic [10:0] lastVector;
    initial instr = 5'h00;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            redirects <= 0;
            lastVector <= 11'h000;
        end else if (fetchRedirect === 1'b1) begin
            redirects <= redirects + 1;
            lastVector <= fetchVector;
        end
    end
    // One instruction a call: 0 en, 1 dis, 2 ret, 3 trap, 4 clear watchdog
    task automatic issue(input int op);
        @(posedge clk);
        instr <= 5'(1 << op);
        @(posedge clk);
        instr <= 5'h00;
    endtask : issue
endmodule : miw_core_model

// *** verification/miw_irq_ctrl_properties.sv ***
// Checker on the ports of the interrupt controller top.
// Assumes one clock domain with an asynchronous active high reset.
`timescale 1ns/1ps
module miw_irq_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic readStrobe,
    input wire logic [7:0] readData,
    input wire logic enableIrqInstr,
    input wire logic disableIrqInstr,
    input wire logic returnFromIsrInstr,
    input wire logic softTrapInstr,
    input wire logic watchdogIrqMode,
    input wire logic fetchRedirect,
    input wire logic [10:0] fetchVector,
    input wire logic globalIrqEnable,
    input wire logic inService,
    input wire logic watchdogChipReset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence trapFetch;
        fetchRedirect && fetchVector == miw_pkg::VEC_SOFT_TRAP && !globalIrqEnable;
    endsequence
    sequence hwFetch;
        fetchRedirect && fetchVector == miw_pkg::VEC_HW_IRQ;
    endsequence
    trap_vector_a: assert property (softTrapInstr |=> trapFetch)
        else $error("trap did not fetch from its vector");
    hw_vector_a: assert property (hwFetch
        |-> $past(globalIrqEnable) && !globalIrqEnable && inService)
        else $error("hardware redirect without global enable");
    gie_set_a: assert property (enableIrqInstr && !globalIrqEnable
        && !softTrapInstr |=> globalIrqEnable)
        else $error("enable instruction left global enable low");
    gie_clear_a: assert property (disableIrqInstr && !enableIrqInstr
        && !returnFromIsrInstr |=> !globalIrqEnable)
        else $error("disable instruction left global enable high");
    isr_return_a: assert property (returnFromIsrInstr && !softTrapInstr
        && !disableIrqInstr |=> globalIrqEnable && !inService)
        else $error("return did not restore state");
    redirect_pulse_a: assert property (fetchRedirect && !softTrapInstr |=> !fetchRedirect)
        else $error("redirect longer than one cycle");
    vector_hold_a: assert property (!$stable(fetchVector) |-> fetchRedirect)
        else $error("vector changed without redirect");
    read_idle_a: assert property (!$past(readStrobe) |-> readData == 8'h00)
        else $error("read data outside its cycle");
    // Pulse reflects the mode of the cycle before it
    wdt_reset_a: assert property (watchdogChipReset
        |-> !$past(watchdogIrqMode) ##1 !watchdogChipReset)
        else $error("chip reset in wrong mode or too long");
endmodule : miw_irq_props

bind miw_irq_ctrl miw_irq_props chk (.clk(clk), .reset(reset), .readStrobe(readStrobe),
    .readData(readData), .enableIrqInstr(enableIrqInstr), .disableIrqInstr(disableIrqInstr),
    .returnFromIsrInstr(returnFromIsrInstr), .softTrapInstr(softTrapInstr),
    .watchdogIrqMode(watchdogIrqMode), .fetchRedirect(fetchRedirect),
    .fetchVector(fetchVector), .globalIrqEnable(globalIrqEnable), .inService(inService),
    .watchdogChipReset(watchdogChipReset));

// *** verification/tb_mcu_interrupt_and_watchdog.sv ***
// Self-checking bench for the interrupt controller and watchdog.
// Assumes the core model drives instructions, the bench all else.
`timescale 1ns/1ps
module tb_mcu_interrupt_and_watchdog;
    logic clk, reset, writeStrobe, readStrobe, comparatorOut, wdtOn, wdtIrq;
    logic fetchRedirect, globalIrqEnable, inService, watchdogChipReset;
    logic [3:0] addr;
    logic [7:0] writeData, readData, portAIn, portAIsInput;
    logic [5:0] portBIn, portBIsInput, evt;
    logic [4:0] instr;
    logic [1:0] wdtSel;
    logic [10:0] fetchVector;
    int miscompares = 0, check_count = 0, cycles = 0, seed, flagM = 0, enM, n, i;
    int src[6] = '{0, 1, 2, 3, 8, 10};

    miw_irq_ctrl #(.WDT_CYC_0(8), .WDT_CYC_1(16), .WDT_CYC_2(32), .WDT_CYC_3(64)) DUT (
        .clk(clk), .reset(reset), .addr(addr), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .enableIrqInstr(instr[0]), .disableIrqInstr(instr[1]),
        .returnFromIsrInstr(instr[2]), .softTrapInstr(instr[3]),
        .clearWatchdogInstr(instr[4]), .timerAOverflow(evt[0]), .timerBUnderflow(evt[1]),
        .timerCUnderflow(evt[2]), .timerDUnderflow(evt[3]), .lowVoltageEvent(evt[4]),
        .conversionDone(evt[5]), .comparatorOut(comparatorOut), .portAIn(portAIn),
        .portBIn(portBIn), .portAIsInput(portAIsInput), .portBIsInput(portBIsInput),
        .watchdogCfgEnable(wdtOn), .watchdogIrqMode(wdtIrq), .watchdogPeriodSel(wdtSel),
        .fetchRedirect(fetchRedirect), .fetchVector(fetchVector),
        .globalIrqEnable(globalIrqEnable), .inService(inService),
        .watchdogChipReset(watchdogChipReset));
    miw_core_model core (.clk(clk), .reset(reset), .fetchRedirect(fetchRedirect),
        .fetchVector(fetchVector), .instr(instr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic give_verdict();
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Hang guard well above the thousand-odd cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clk);
        writeStrobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        readStrobe <= 1'b1;
        @(posedge clk);
        readStrobe <= 1'b0;
        #1 d = readData;
    endtask : rd
    // Comparator level bit masked: it shows the live comparatorOut level
    task automatic chkFlags();
        logic [7:0] d;
        rd(4'h0, d);
        chk("flags low", 11'(flagM & enM & 'hff), 11'(d));
        rd(4'h8, d);
        chk("flags high", 11'({1'b0, 3'(enM >> 8), 1'b0, 3'((flagM & enM) >> 8)}), 11'(d & 8'h7f));
    endtask : chkFlags
    task automatic pulse(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt[k] <= 1'b0;
        @(posedge clk);
        flagM |= 1 << src[k];
    endtask : pulse
    task automatic stim(input logic [7:0] a, input logic [5:0] b, input logic c, input int add);
        @(posedge clk);
        // Pins without wake enable toggle at random and must raise nothing
        portAIn <= a | (8'($random(seed)) & 8'hfc);
        portBIn <= b | (6'($random(seed)) & 6'h3c);
        comparatorOut <= c;
        repeat (3) @(posedge clk);
        flagM |= add;
        chkFlags();
    endtask : stim
    task automatic measure(output int c);
        while (watchdogChipReset !== 1'b1) @(negedge clk);
        @(negedge clk);
        c = 1;
        while (watchdogChipReset !== 1'b1) begin
            @(negedge clk);
            c++;
        end
    endtask : measure

    initial begin
        logic [7:0] d;
        int w;
        seed = 55897;
        reset = 1'b1;
        {addr, writeData, writeStrobe, readStrobe, evt, portAIn, portBIn} = '0;
        {comparatorOut, wdtOn, wdtIrq, wdtSel} = '0;
        // Port A pin 0 always input, pin 1 never: both sides of the input gate
        portAIsInput = (8'($random(seed)) | 8'h01) & 8'hfd;
        portBIsInput = 6'($random(seed)) | 6'h02;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(4'h3, d);
        chk("power", 11'h080, 11'(d));
        rd(4'h2, d);
        chk("timeout status", 11'h001, 11'(d[4]));
        rd(4'h4, d);
        chk("prescale", 11'h000, 11'(d));
        wr(4'h9, 8'hff);
        rd(4'h9, d);
        chk("unmapped", 11'h000, 11'(d));
        for (i = 0; i < 4; i++) begin
            enM = $random(seed) & 'h7ff;
            wr(4'h1, enM[7:0]);
            wr(4'h8, {1'b0, 3'(enM >> 8), 4'h7});
            for (n = 0; n < 6; n++) pulse(n);
            chkFlags();
            wr(4'h0, 8'hfe);
            flagM &= ~1;
            chkFlags();
            wr(4'h0, 8'h00);
            wr(4'h8, {1'b0, 3'(enM >> 8), 4'h0});
            flagM = 0;
        end
        enM = 'h7ff;
        wr(4'h1, 8'hff);
        wr(4'h8, 8'h77);
        core.issue(0);
        #1 chk("gie on", 11'h001, 11'(globalIrqEnable));
        pulse(1);
        #1 chk("irq vector", 11'h008, fetchVector);
        chk("gie taken", 11'h000, 11'(globalIrqEnable));
        chk("in service", 11'h001, 11'(inService));
        pulse(5);
        chkFlags();
        wr(4'h0, 8'h00);
        flagM &= ~2;
        core.issue(0);
        repeat (3) @(posedge clk);
        chk("nested", 11'h002, 11'(core.redirects));
        wr(4'h8, 8'h70);
        flagM = 0;
        for (n = 0; n < 2; n++) begin
            core.issue(2);
            #1 chk("return gie", 11'h001, 11'(globalIrqEnable));
            chk("return service", 11'h000, 11'(inService));
            if (n == 1) core.issue(1);
            core.issue(3);
            #1 chk("trap vector", 11'h001, fetchVector);
            chk("trap gie", 11'h000, 11'(globalIrqEnable));
        end
        core.issue(2);
        core.issue(1);
        chk("redirects", 11'h004, 11'(core.redirects));
        wr(4'h5, 8'h03);
        wr(4'h6, 8'h03);
        wr(4'h7, 8'h05);
        stim(8'h02, 6'h00, 1'b0, 0);
        stim(8'h03, 6'h00, 1'b0, 'h80);
        wr(4'h0, 8'h00);
        flagM = 0;
        stim(8'h03, 6'h01, 1'b0, 'h10);
        stim(8'h03, 6'h00, 1'b0, 0);
        stim(8'h03, 6'h02, 1'b0, 'h80);
        rd(4'h8, d);
        stim(8'h03, 6'h02, 1'b1, 'h200);
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h70);
        flagM = 0;
        wdtOn <= 1'b1;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            wdtSel <= 2'(n);
            repeat (2) @(posedge clk);
            measure(w);
            chk("wdt period", 11'(8 << n), 11'(w));
        end
        wr(4'h4, 8'h0a);
        measure(w);
        chk("wdt prescaled", 11'h100, 11'(w));
        rd(4'h2, d);
        chk("timeout cleared", 11'h000, 11'(d[4]));
        core.issue(4);
        rd(4'h2, d);
        chk("timeout set", 11'h001, 11'(d[4]));
        wdtOn <= 1'b0;
        wr(4'h4, 8'h08);
        wdtIrq <= 1'b1;
        wdtSel <= 2'h0;
        core.issue(4);
        wdtOn <= 1'b1;
        repeat (24) @(posedge clk);
        flagM |= 'h40;
        chkFlags();
        wr(4'h3, 8'h00);
        core.issue(4);
        wr(4'h0, 8'h00);
        flagM = 0;
        repeat (60) @(posedge clk);
        chkFlags();
        give_verdict();
    end
endmodule : tb_mcu_interrupt_and_watchdog
